//--- include/iswe_pkg.sv
package iswe_pkg;
	//----------------------------------------
	// Status word layout
	//----------------------------------------
	localparam int          B_ACC     = 15;
	localparam int          B_TMO     = 14;
	localparam int          B_RTME    = 13;
	localparam int          B_SAEV    = 7;
	localparam int          B_MCND    = 6;
	localparam int          B_IBC     = 5;
	localparam int          B_ILC     = 4;
	localparam int          B_POLL    = 3;
	localparam int          B_RTRY    = 2;
	localparam int          B_ME      = 1;
	localparam int          B_IAC     = 0;
	localparam logic [15:0] RSVD_MASK = 16'h1f00;
	localparam logic [15:0] CAUSE_MSK = 16'h60ff;
	localparam logic [15:0] ACC_MASK  = 16'h8000;

	//----------------------------------------
	// Register map and reset values
	//----------------------------------------
	localparam logic [7:0]  OFS_CTRL  = 8'h00;
	localparam logic [7:0]  OFS_EN    = 8'h04;
	localparam logic [7:0]  OFS_LOGP  = 8'h08;
	localparam logic [7:0]  OFS_LAST  = 8'h0c;
	localparam logic [7:0]  OFS_STAT  = 8'h10;
	localparam int          CTRL_LOG  = 0;
	localparam int          CTRL_BC   = 1;
	localparam logic [1:0]  CTRL_RST  = 2'h0;
	localparam logic [15:0] EN_RST    = 16'h0000;
	localparam logic [15:0] LOGP_RST  = 16'h0000;

	//----------------------------------------
	// Entry layout in memory (word offsets)
	//----------------------------------------
	localparam logic [15:0] ENT_PTR   = 16'h0001;
	localparam logic [15:0] ENT_TAIL  = 16'h0002;
	localparam logic [7:0]  CNT_ONE   = 8'h01;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_ISW  = 4'h2,
		ST_PTR  = 4'h4,
		ST_TAIL = 4'h8
	} iswe_state_e;

	typedef struct packed {
		logic        me_evt;
		logic        no_resp;
		logic        rt_sts_me;
		logic        sa_access;
		logic        ivc_bit;
		logic        iz_bit;
		logic        idx_zero;
		logic        mc_nodata;
		logic        iwa_en;
		logic        bcast_rx;
		logic        illeg_mc_sa;
		logic        illeg_cmd;
		logic        invalid_cmd;
		logic        poll_irq;
		logic        retry_fail;
		logic        retries_done;
		logic        ic_req;
		logic [15:0] ptr;
	} iswe_evt_s;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} iswe_apb_req_s;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} iswe_apb_rsp_s;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [15:0] addr;
		logic [15:0] wdata;
	} iswe_dma_req_s;

	typedef struct packed {
		logic        ack;
		logic [15:0] rdata;
	} iswe_dma_rsp_s;
endpackage

//--- rtl/iswe_encode.sv
module iswe_encode (
	input  wire logic              mode_bc,
	input  wire iswe_pkg::iswe_evt_s evt,
	output logic [15:0]            cause
);
	import iswe_pkg::*;

	logic rt;

	assign rt = ~mode_bc;

	//----------------------------------------
	// Cause bits, each high when its cause occurred
	//----------------------------------------
	always_comb begin
		cause         = 16'h0000;
		cause[B_TMO]  = evt.me_evt & evt.no_resp;
		cause[B_RTME] = evt.rt_sts_me;
		cause[B_SAEV] = rt & evt.sa_access & (evt.ivc_bit | (evt.iz_bit & evt.idx_zero));
		cause[B_MCND] = rt & evt.mc_nodata & evt.iwa_en;
		cause[B_IBC]  = rt & evt.bcast_rx & evt.illeg_mc_sa & ~evt.invalid_cmd;
		cause[B_ILC]  = rt & evt.illeg_cmd & ~evt.invalid_cmd;
		cause[B_POLL] = mode_bc & evt.poll_irq;
		cause[B_RTRY] = mode_bc & evt.retry_fail & evt.retries_done;
		cause[B_ME]   = evt.me_evt;
		cause[B_IAC]  = mode_bc & evt.ic_req;
	end
endmodule

//--- rtl/iswe_pend.sv
module iswe_pend (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [15:0] set,
	input  wire logic [15:0] set_ptr,
	input  wire logic        take,
	output logic [15:0]      word,
	output logic [15:0]      ptr
);
	import iswe_pkg::*;

	typedef struct packed {
		logic [15:0] word;
		logic [15:0] ptr;
	} iswe_pend_s;

	iswe_pend_s s_q;
	iswe_pend_s s_d;

	//----------------------------------------
	// Sticky causes, a new cause survives a take
	//----------------------------------------
	always_comb begin
		s_d = s_q;
		if (take) begin
			s_d.word = set;
		end else begin
			s_d.word = s_q.word | set;
		end
		if (|set) begin
			s_d.ptr = set_ptr;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign word = s_q.word;
	assign ptr  = s_q.ptr;
endmodule

//--- rtl/iswe_top.sv
// Chosen here: the address map and the APB interface to the registers.
module iswe_top (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire iswe_pkg::iswe_apb_req_s apb_req,
	output iswe_pkg::iswe_apb_rsp_s    apb_rsp,
	input  wire iswe_pkg::iswe_evt_s   evt,
	output iswe_pkg::iswe_dma_req_s    dma_req,
	input  wire iswe_pkg::iswe_dma_rsp_s dma_rsp,
	output logic                       busy
);
	import iswe_pkg::*;

	typedef struct packed {
		iswe_state_e   st;
		logic [1:0]    ctrl;
		logic [15:0]   en;
		logic [15:0]   logp;
		logic [15:0]   last;
		logic [15:0]   cur_isw;
		logic [15:0]   cur_ptr;
		logic [7:0]    cnt;
		logic [31:0]   rdata;
		logic          err;
		iswe_dma_req_s dma;
	} iswe_top_s;

	iswe_top_s   s_q;
	iswe_top_s   s_d;
	logic [15:0] cause;
	logic [15:0] gated;
	logic [15:0] pend_word;
	logic [15:0] pend_ptr;
	logic        take;
	logic        setup;
	logic        access;
	logic        wr_acc;
	logic        hit;

	//----------------------------------------
	// Cause encoding and sticky capture
	//----------------------------------------
	iswe_encode u_enc (
		.mode_bc (s_q.ctrl[CTRL_BC]),
		.evt     (evt),
		.cause   (cause)
	);

	// Disabled causes never reach the pending word
	assign gated = cause & s_q.en & CAUSE_MSK;

	iswe_pend u_pend (
		.pclk    (pclk),
		.presetn (presetn),
		.set     (gated),
		.set_ptr (evt.ptr),
		.take    (take),
		.word    (pend_word),
		.ptr     (pend_ptr)
	);

	//----------------------------------------
	// APB phase decode
	//----------------------------------------
	assign setup  = apb_req.psel & ~apb_req.penable;
	assign access = apb_req.psel & apb_req.penable;
	assign wr_acc = access & apb_req.pwrite;
	assign hit    = (apb_req.paddr == OFS_CTRL) | (apb_req.paddr == OFS_EN) |
		(apb_req.paddr == OFS_LOGP) | (apb_req.paddr == OFS_LAST) |
		(apb_req.paddr == OFS_STAT);
	assign take   = (s_q.st == ST_IDLE) & s_q.ctrl[CTRL_LOG] & (|pend_word);

	//----------------------------------------
	// Next state: registers, read data, entry writer
	//----------------------------------------
	always_comb begin
		s_d = s_q;
		// Read data and error latched in setup, shown in access
		if (setup) begin
			s_d.err   = ~hit;
			s_d.rdata = 32'h0000_0000;
			case (apb_req.paddr)
				OFS_CTRL: s_d.rdata[1:0]  = s_q.ctrl;
				OFS_EN:   s_d.rdata[15:0] = s_q.en;
				OFS_LOGP: s_d.rdata[15:0] = s_q.logp;
				OFS_LAST: s_d.rdata[15:0] = s_q.last;
				OFS_STAT: s_d.rdata[15:0] = {s_q.cnt, 6'h00, |pend_word, busy};
				default:  s_d.rdata       = 32'h0000_0000;
			endcase
		end
		// Register writes take effect at the access edge, LOGP writes only while idle
		if (wr_acc) begin
			case (apb_req.paddr)
				OFS_CTRL: s_d.ctrl = apb_req.pwdata[1:0];
				OFS_EN:   s_d.en   = apb_req.pwdata[15:0] & CAUSE_MSK;
				OFS_LOGP: begin
					if (s_q.st == ST_IDLE) begin
						s_d.logp = apb_req.pwdata[15:0];
					end
				end
				default: s_d.en = s_q.en;
			endcase
		end
		// Entry sequence: status word, pointer, then tail read
		case (s_q.st)
			ST_IDLE: begin
				if (take) begin
					s_d.cur_isw    = pend_word | ACC_MASK;
					s_d.cur_ptr    = pend_ptr;
					s_d.st         = ST_ISW;
					s_d.dma.req    = 1'b1;
					s_d.dma.we     = 1'b1;
					s_d.dma.addr   = s_q.logp;
					s_d.dma.wdata  = (pend_word & ~RSVD_MASK) | ACC_MASK;
				end
			end
			ST_ISW: begin
				if (dma_rsp.ack) begin
					s_d.st        = ST_PTR;
					s_d.dma.addr  = s_q.logp + ENT_PTR;
					s_d.dma.wdata = s_q.cur_ptr;
				end
			end
			ST_PTR: begin
				if (dma_rsp.ack) begin
					s_d.st        = ST_TAIL;
					s_d.dma.we    = 1'b0;
					s_d.dma.addr  = s_q.logp + ENT_TAIL;
					s_d.dma.wdata = 16'h0000;
				end
			end
			ST_TAIL: begin
				if (dma_rsp.ack) begin
					// Tail pointer locates the next entry
					s_d.st      = ST_IDLE;
					s_d.logp    = dma_rsp.rdata;
					s_d.last    = s_q.cur_isw;
					s_d.cnt     = s_q.cnt + CNT_ONE;
					s_d.dma.req = 1'b0;
				end
			end
			default: begin
				s_d.st      = ST_IDLE;
				s_d.dma.req = 1'b0;
			end
		endcase
	end

	//----------------------------------------
	// State register
	//----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q.st      <= ST_IDLE;
			s_q.ctrl    <= CTRL_RST;
			s_q.en      <= EN_RST;
			s_q.logp    <= LOGP_RST;
			s_q.last    <= 16'h0000;
			s_q.cur_isw <= 16'h0000;
			s_q.cur_ptr <= 16'h0000;
			s_q.cnt     <= 8'h00;
			s_q.rdata   <= 32'h0000_0000;
			s_q.err     <= 1'b0;
			s_q.dma     <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	//----------------------------------------
	// Outputs
	//----------------------------------------
	// Every access phase completes without wait states
	assign apb_rsp.pready  = 1'b1;
	assign apb_rsp.pslverr = access & s_q.err;
	assign apb_rsp.prdata  = s_q.rdata;
	assign dma_req         = s_q.dma;
	assign busy            = (s_q.st != ST_IDLE);

	//----------------------------------------
	// Assertions
	//----------------------------------------
	a_acc_bit_set: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.st == ST_ISW) |-> (dma_req.req & dma_req.we & dma_req.wdata[B_ACC]))
		else $error("accessed bit missing in status word write");

	a_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.st == ST_ISW) |-> ((dma_req.wdata & RSVD_MASK) == 16'h0000))
		else $error("reserved bits not zero");

	a_only_enabled: assert property (@(posedge pclk) disable iff (!presetn)
		(take & ~wr_acc) |=> ((dma_req.wdata & ~ACC_MASK & ~s_q.en) == 16'h0000))
		else $error("disabled cause logged");

	a_entry_order: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.st == ST_ISW && dma_rsp.ack) |=> (s_q.st == ST_PTR) &&
		(dma_req.addr == $past(dma_req.addr) + ENT_PTR) && dma_req.we)
		else $error("pointer write does not follow status word");

	a_tail_read: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.st == ST_TAIL && dma_rsp.ack) |=> (s_q.logp == $past(dma_rsp.rdata)) &&
		!dma_req.req)
		else $error("tail pointer not taken as next entry");

	a_tmo_cause: assert property (@(posedge pclk) disable iff (!presetn)
		cause[B_TMO] |-> cause[B_ME])
		else $error("time-out flag without message error");

	a_illeg_bc: assert property (@(posedge pclk) disable iff (!presetn)
		(evt.invalid_cmd | s_q.ctrl[CTRL_BC]) |-> !cause[B_IBC] && !cause[B_ILC])
		else $error("illegal flag for invalid command or controller mode");

	a_retry_fail: assert property (@(posedge pclk) disable iff (!presetn)
		!evt.retries_done |-> !cause[B_RTRY])
		else $error("retry fail before all retries");

	a_bc_modes: assert property (@(posedge pclk) disable iff (!presetn)
		!s_q.ctrl[CTRL_BC] |-> !(cause[B_POLL] | cause[B_RTRY] | cause[B_IAC]))
		else $error("controller flag in terminal mode");

	a_sa_event: assert property (@(posedge pclk) disable iff (!presetn)
		cause[B_SAEV] |-> evt.sa_access && (evt.ivc_bit || (evt.iz_bit && evt.idx_zero)))
		else $error("subaddress event without cause");

	a_me_both: assert property (@(posedge pclk) disable iff (!presetn)
		evt.me_evt |-> cause[B_ME])
		else $error("message error flag missing");

	c_entry_done: cover property (@(posedge pclk) disable iff (!presetn)
		(s_q.st == ST_TAIL) && dma_rsp.ack);

	c_set_on_take: cover property (@(posedge pclk) disable iff (!presetn)
		take && (|gated));

	c_logp_write: cover property (@(posedge pclk) disable iff (!presetn)
		wr_acc && (apb_req.paddr == OFS_LOGP));
endmodule

//--- tb/iswe_host_mem.sv
module iswe_host_mem (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    slow,
	input  wire iswe_pkg::iswe_dma_req_s dma_req,
	output iswe_pkg::iswe_dma_rsp_s      dma_rsp
);
	timeunit 1ns;
	timeprecision 1ps;
	import iswe_pkg::*;
	logic [15:0] mem [int];
	int          wait_n;
	int          k;
	//----------------------------------------
	// Shared memory, ack after 0 or 3 stalls
	//----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		k = int'(dma_req.addr);
		if (!presetn) begin
			dma_rsp <= '0;
			wait_n = 0;
		end else if (dma_rsp.ack || !dma_req.req) begin
			dma_rsp.ack <= 1'b0;
			dma_rsp.rdata <= ~dma_rsp.rdata; // Stale data not held
		end else if (wait_n < (slow ? 3 : 0)) begin
			wait_n++;
			dma_rsp.rdata <= ~dma_rsp.rdata;
		end else begin
			wait_n = 0;
			dma_rsp.ack <= 1'b1;
			if (dma_req.we)
				mem[k] = dma_req.wdata;
			else
				dma_rsp.rdata <= mem.exists(k) ? mem[k] : 16'h0;
		end
	end
endmodule

//--- tb/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import iswe_pkg::*;
	logic          pclk;
	logic          presetn;
	logic          slow;
	logic          busy;
	iswe_apb_req_s apb_req;
	iswe_apb_rsp_s apb_rsp;
	iswe_evt_s     evt;
	iswe_dma_req_s dma_req;
	iswe_dma_rsp_s dma_rsp;
	int            n_mismatch;
	int            checks;
	int            n_ent;
	logic [31:0]   rd;
	logic          err;
	logic [15:0]   logp;
	logic [15:0]   en;
	logic          bc;

	iswe_top DUT (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.evt(evt), .dma_req(dma_req), .dma_rsp(dma_rsp), .busy(busy));
	iswe_host_mem HOST (.pclk(pclk), .presetn(presetn), .slow(slow),
		.dma_req(dma_req), .dma_rsp(dma_rsp));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("mismatches %0d, comparisons %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// APB master, holds request until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic rdy;
		@(posedge pclk);
		apb_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge pclk);
			rd = apb_rsp.prdata;
			err = apb_rsp.pslverr;
			rdy = apb_rsp.pready;
		end while (rdy !== 1'b1);
		apb_req <= '0;
	endtask

	// Reference encoding of one event
	function automatic logic [15:0] cause(input logic m, input iswe_evt_s e);
		logic [15:0] c;
		c = '0;
		c[14] = e.me_evt && e.no_resp;
		c[13] = e.rt_sts_me;
		c[7] = !m && e.sa_access && (e.ivc_bit || (e.iz_bit && e.idx_zero));
		c[6] = !m && e.mc_nodata && e.iwa_en;
		c[5] = !m && e.bcast_rx && e.illeg_mc_sa && !e.invalid_cmd;
		c[4] = !m && e.illeg_cmd && !e.invalid_cmd;
		c[3] = m && e.poll_irq;
		c[2] = m && e.retry_fail && e.retries_done;
		c[1] = e.me_evt;
		c[0] = m && e.ic_req;
		return c & en;
	endfunction

	// Pulse one event, then check the log entry; hold keeps logging off first
	task automatic fire(input iswe_evt_s e, input logic hold);
		logic [15:0] x;
		int          n;
		logic        seen;
		x = cause(bc, e);
		seen = 1'b0;
		HOST.mem[int'(logp) + 2] = logp + 16'h3;
		if (hold)
			apb(1'b1, OFS_CTRL, {30'h0, bc, 1'b0});
		@(posedge pclk);
		evt <= e;
		@(posedge pclk);
		evt <= '0;
		if (hold) begin
			repeat (20) @(negedge pclk) seen |= busy;
			chk(seen, 1'b0, "entry while log off");
			apb(1'b0, OFS_STAT, 32'h0);
			chk(rd[1], x != 16'h0, "pending while log off");
			apb(1'b1, OFS_CTRL, {30'h0, bc, 1'b1});
		end
		for (n = 0; n < 60 && !(seen && !busy); n++) begin
			@(negedge pclk);
			seen |= busy;
		end
		chk(seen, x != 16'h0, "entry written");
		if (x != 16'h0) begin
			chk(HOST.mem[int'(logp)], x | 16'h8000, "status");
			chk(HOST.mem[int'(logp) + 1], e.ptr, "pointer");
			HOST.mem[int'(logp)][15] = 1'b0;
			logp += 16'h3;
			n_ent++;
			apb(1'b0, OFS_LAST, 32'h0);
			chk(rd, {16'h0, x | 16'h8000}, "last word");
			apb(1'b0, OFS_LOGP, 32'h0);
			chk(rd, {16'h0, logp}, "next entry");
			apb(1'b0, OFS_STAT, 32'h0);
			chk(rd, {16'h0, n_ent[7:0], 8'h0}, "count");
		end
	endtask

	initial begin
		#500us;
		n_mismatch++;
		end_sim();
	end

	initial begin
		iswe_evt_s e;
		n_mismatch = 0;
		checks = 0;
		n_ent = 0;
		presetn = 1'b0;
		slow = 1'b0;
		apb_req = '0;
		evt = '0;
		logp = 16'h0100;
		en = 16'h0;
		bc = 1'b0;
		void'($urandom(32'h269d));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values, then unmapped slot
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0);
			chk(rd, 32'h0, "reset value");
			chk(err, i == 5, "slave error");
		end
		apb(1'b1, OFS_EN, 32'hffffffff);
		apb(1'b0, OFS_EN, 32'h0);
		chk(rd, 32'h60ff, "enable mask");
		apb(1'b1, OFS_LOGP, {16'h0, logp});
		$display("test registers done");
		for (int m = 0; m < 2; m++) begin
			bc = m[0];
			apb(1'b1, OFS_CTRL, {30'h0, bc, 1'b1});
			en = 16'h0;
			apb(1'b1, OFS_EN, 32'h0);
			e = '0;
			e.me_evt = 1'b1;
			fire(e, 1'b0);
			en = 16'h60ff;
			apb(1'b1, OFS_EN, {16'h0, en});
			fire(e, 1'b1);
			repeat (40) begin
				en = $urandom_range(0, 1) ? 16'h60ff : 16'($urandom) & 16'h60ff;
				slow <= 1'($urandom_range(0, 1));
				apb(1'b1, OFS_EN, {16'h0, en});
				e = 33'({$urandom, $urandom});
				fire(e, 1'b0);
			end
			$display("test mode %0d done", m);
		end
		end_sim();
	end
endmodule
